// >>> inc/isf_pkg.sv
// Constants shared by the input select and fault monitor block
package isf_pkg;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_PRIO      = 8'h04;
    localparam logic [7:0] OFS_LOS_LIM   = 8'h08;
    localparam logic [7:0] OFS_OOF_WIN   = 8'h0C;
    localparam logic [7:0] OFS_OOF_EXP   = 8'h10;
    localparam logic [7:0] OFS_LOL_THR   = 8'h14;
    localparam logic [7:0] OFS_LOL_TIMER = 8'h18;
    localparam logic [7:0] OFS_LIVE      = 8'h1C;
    localparam logic [7:0] OFS_STICKY    = 8'h20;
    // ==========================================================
    // Control register fields
    localparam int CTL_SEL_REG   = 0;
    localparam int CTL_REG_SEL   = 1;
    localparam int CTL_AUTO      = 3;
    localparam int CTL_REVERT    = 4;
    localparam int CTL_HITLESS   = 5;
    localparam int CTL_RAMP      = 6;
    localparam int CTL_FASTLOCK  = 7;
    localparam int CTL_ZDM       = 8;
    localparam int CTL_KEEP_OUT  = 9;
    localparam int CTL_OOF_REF   = 10;
    localparam int CTL_LOS_EN    = 13;
    localparam int CTL_PREC_EN   = 17;
    localparam int CTL_FAST_EN   = 18;
    localparam int CTL_XLOS_EN   = 19;
    // ==========================================================
    // Status bit positions (live has all; sticky shares them up to ST_UNLOCK)
    localparam int ST_LOS      = 0;
    localparam int ST_OOF      = 4;
    localparam int ST_XLOS     = 8;
    localparam int ST_UNLOCK   = 9;
    localparam int ST_ACT      = 10;
    localparam int ST_HOLD     = 12;
    localparam int STICKY_BITS = 10;
    // ==========================================================
    // Reset values
    localparam logic [31:0] CTRL_RST      = 32'h000F_E000;
    localparam logic [31:0] PRIO_RST      = 32'h0000_0688;
    localparam logic [31:0] LOS_LIM_RST   = 32'h4040_4040;
    localparam logic [31:0] OOF_WIN_RST   = 32'h0002_0008;
    localparam logic [31:0] OOF_EXP_RST   = 32'h0100_0FA0;
    localparam logic [31:0] LOL_THR_RST   = 32'h0001_0004;
    localparam logic [31:0] LOL_TIMER_RST = 32'h0000_0100;
    // ==========================================================
    // Timing: frequency gate window
    localparam int GATE_US  = 100;
    localparam int CLK_MHZ  = 40;
    localparam int GATE_CYC = GATE_US * CLK_MHZ;
    localparam int XLOS_CYC = 64;
    localparam int SYNC_W   = 8;
endpackage

// >>> rtl/isf_top.sv
// Input clock selection and fault monitoring, AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Select pin code 00..11 picks inputs 0..3
// - Control bit picks pins or register; pins default
// - Automatic choice considers only valid inputs
// - No valid input means holdover
// - Revertive: always highest priority valid input
// - Non-revertive: keep active input while valid
// - Hitless enable absorbs phase on locked inputs
// - Hitless off passes phase at loop rate
// - Ramped switching shares holdover exit ramp settings
// - Glitchless pull-in uses normal or fast bandwidth
// - Unlocked held during pull-in, no runts
// - Zero delay closes loop through fourth input
// - Zero delay removes fourth input from selection
// - Monitor inputs for absence and excursion; crystal absence
// - Per-input period absence monitor, sensitivity, disable
// - Live and sticky absence status per input
// - Crystal absence disables outputs unless kept
// - Excursion reference: expected count or input; fourth not in zero delay
// - Precise and fast excursion combined, live and sticky
// - Precise window with hysteresis
// - Fast monitor flags large change between windows
// - Lock set and clear monitors give hysteresis
// - Unlocked pin, live and sticky unlocked status
// - Timer delays clearing of unlocked indicator
module isf_top #(
    parameter int GATE = isf_pkg::GATE_CYC,
    parameter int CW   = 16
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        ref_clock_a,
    input  wire logic        ref_clock_b,
    input  wire logic        ref_clock_c,
    input  wire logic        ref_clock_d_or_feedback,
    input  wire logic        loop_fb_clk,
    input  wire logic        crystal_reference,
    input  wire logic [1:0]  in_sel_pins,
    output logic             unlocked_pin_n,
    output logic [1:0]       active_input,
    output logic             holdover,
    output logic             switch_start,
    output logic             hitless_en,
    output logic             ramp_en,
    output logic             fastlock_en,
    output logic             ext_feedback_en,
    output logic             outputs_enable
);
    // ==========================================================
    // Reset release and pin synchronisers
    logic              rst_q1, rst_n;
    logic [7:0]        pin_raw, s1, s2, s3;
    logic [5:0]        edge_hit;

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_q1 <= 1'b0;
            rst_n  <= 1'b0;
        end
        else
        begin
            rst_q1 <= 1'b1;
            rst_n  <= rst_q1;
        end
    end

    assign pin_raw = {in_sel_pins, crystal_reference, loop_fb_clk, ref_clock_d_or_feedback,
                      ref_clock_c, ref_clock_b, ref_clock_a};

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1 <= 8'h00;
            s2 <= 8'h00;
            s3 <= 8'h00;
        end
        else
        begin
            s1 <= pin_raw;
            s2 <= s1;
            s3 <= s2;
        end
    end
    assign edge_hit = s2[5:0] & ~s3[5:0];

    // ==========================================================
    // Registers
    localparam int STICKY_BITS_W = isf_pkg::STICKY_BITS;
    logic [31:0] ctrl_r, prio_r, los_lim_r, oof_win_r, oof_exp_r, lol_thr_r, lol_tmr_r;
    logic [STICKY_BITS_W-1:0] sticky_r;
    logic [31:0] live;
    logic        ph_wr, ph_act;
    logic [7:0]  ph_addr;
    logic        zero_delay_setting;

    assign zero_delay_setting             = ctrl_r[isf_pkg::CTL_ZDM];
    assign ext_feedback_en = zero_delay_setting;
    assign hitless_en      = ctrl_r[isf_pkg::CTL_HITLESS];
    assign ramp_en         = ctrl_r[isf_pkg::CTL_RAMP];
    assign fastlock_en     = ctrl_r[isf_pkg::CTL_FASTLOCK];
    assign hreadyout       = 1'b1;
    assign hresp           = 1'b0;

    // ==========================================================
    // Frequency gate and per-signal edge counts
    logic [CW-1:0] gate_cnt;
    logic          gate_end;
    logic [CW-1:0] ecnt [5];
    logic [CW-1:0] meas [5];
    logic [CW-1:0] prev [4];
    logic          meas_ok;

    assign gate_end = (gate_cnt == CW'(GATE - 1));

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            gate_cnt <= '0;
        else if (gate_end)
            gate_cnt <= '0;
        else
            gate_cnt <= gate_cnt + 1'b1;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meas_ok <= 1'b0;
            for (int i = 0; i < 5; i++)
            begin
                ecnt[i] <= '0;
                meas[i] <= '0;
            end
            for (int i = 0; i < 4; i++)
                prev[i] <= '0;
        end
        else
        begin
            for (int i = 0; i < 5; i++)
            begin
                if (gate_end)
                begin
                    meas[i] <= ecnt[i] + CW'(edge_hit[i]);
                    ecnt[i] <= '0;
                end
                else
                    ecnt[i] <= ecnt[i] + CW'(edge_hit[i]);
            end
            if (gate_end)
            begin
                meas_ok <= 1'b1;
                for (int i = 0; i < 4; i++)
                    prev[i] <= meas[i];
            end
        end
    end

    function automatic logic [CW-1:0] adiff(input logic [CW-1:0] a, input logic [CW-1:0] b);
        adiff = (a > b) ? a - b : b - a;
    endfunction

    // ==========================================================
    // Signal absence: period since last edge against per-input limit
    logic [7:0] per_cnt [4];
    logic [3:0] signal_absent_flag;
    logic [6:0] xcnt;
    logic       xlos;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            signal_absent_flag <= 4'h0;
            for (int i = 0; i < 4; i++)
                per_cnt[i] <= '0;
        end
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (edge_hit[i])
                    per_cnt[i] <= '0;
                else if (per_cnt[i] != 8'hFF)
                    per_cnt[i] <= per_cnt[i] + 1'b1;
                signal_absent_flag[i] <= ctrl_r[isf_pkg::CTL_LOS_EN + i] &&
                          (per_cnt[i] >= los_lim_r[8*i +: 8]);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            xcnt <= '0;
            xlos <= 1'b0;
        end
        else
        begin
            if (edge_hit[5])
                xcnt <= '0;
            else if (xcnt != 7'(isf_pkg::XLOS_CYC))
                xcnt <= xcnt + 1'b1;
            xlos <= ctrl_r[isf_pkg::CTL_XLOS_EN] && (xcnt == 7'(isf_pkg::XLOS_CYC));
        end
    end

    assign outputs_enable = ctrl_r[isf_pkg::CTL_KEEP_OUT] || !xlos;

    // ==========================================================
    // Frequency excursion: precise window with hysteresis plus fast step
    logic [2:0]    oof_ref;
    logic [CW-1:0] ref_cnt;
    logic [3:0]    oof_prec, oof_fast, freq_excursion_flag;
    logic [CW-1:0] dev [4];

    assign oof_ref = ctrl_r[isf_pkg::CTL_OOF_REF +: 3];

    always_comb
    begin
        ref_cnt = oof_exp_r[CW-1:0];
        if (oof_ref >= 3'd1 && oof_ref <= 3'd4 && !(oof_ref == 3'd4 && zero_delay_setting))
            ref_cnt = meas[oof_ref[1:0] - 2'd1];
    end

    always_comb
        for (int i = 0; i < 4; i++)
            dev[i] = adiff(meas[i], ref_cnt);

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            oof_prec <= 4'h0;
            oof_fast <= 4'h0;
        end
        else if (gate_end && meas_ok)
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (!ctrl_r[isf_pkg::CTL_PREC_EN])
                    oof_prec[i] <= 1'b0;
                else if (dev[i] > oof_win_r[CW-1:0])
                    oof_prec[i] <= 1'b1;
                else if ({1'b0, dev[i]} + {1'b0, oof_win_r[16 +: CW]} <= {1'b0, oof_win_r[CW-1:0]})
                    oof_prec[i] <= 1'b0;
                oof_fast[i] <= ctrl_r[isf_pkg::CTL_FAST_EN] &&
                               (adiff(meas[i], prev[i]) > oof_exp_r[16 +: CW]);
            end
        end
    end

    assign freq_excursion_flag = oof_prec | oof_fast;

    // ==========================================================
    // Input selection
    typedef enum logic [0:0] {SEL_HOLD = 1'b0, SEL_TRACK = 1'b1} isf_sel_t;
    isf_sel_t   sel_st;
    logic [3:0] valid;
    logic [1:0] best, man_sel, act_r;
    logic       any_valid;

    always_comb
    begin
        best      = 2'd0;
        any_valid = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            valid[i] = !signal_absent_flag[i] && !freq_excursion_flag[i] && !(i == 3 && zero_delay_setting);
            if (valid[i] && (!any_valid ||
                prio_r[3*i +: 3] < prio_r[3*best +: 3]))
            begin
                best      = 2'(i);
                any_valid = 1'b1;
            end
        end
        man_sel = ctrl_r[isf_pkg::CTL_SEL_REG] ? ctrl_r[isf_pkg::CTL_REG_SEL +: 2]
                                                : s2[7:6];
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sel_st       <= SEL_HOLD;
            act_r        <= 2'd0;
            switch_start <= 1'b0;
        end
        else
        begin
            switch_start <= 1'b0;
            if (!ctrl_r[isf_pkg::CTL_AUTO])
            begin
                sel_st <= valid[man_sel] ? SEL_TRACK : SEL_HOLD;
                act_r  <= man_sel;
                switch_start <= valid[man_sel] && (act_r != man_sel || sel_st == SEL_HOLD);
            end
            else
            begin
                unique case (sel_st)
                    SEL_HOLD:
                    begin
                        if (any_valid)
                        begin
                            sel_st       <= SEL_TRACK;
                            act_r        <= best;
                            switch_start <= 1'b1;
                        end
                    end
                    SEL_TRACK:
                    begin
                        if (!any_valid)
                            sel_st <= SEL_HOLD;
                        else if ((ctrl_r[isf_pkg::CTL_REVERT] || !valid[act_r]) &&
                                 best != act_r)
                        begin
                            act_r        <= best;
                            switch_start <= 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    assign holdover     = (sel_st == SEL_HOLD);
    assign active_input = act_r;

    // ==========================================================
    // Lock monitor with set/clear hysteresis and clear delay
    logic [CW-1:0] lock_dev;
    logic [CW-1:0] lol_tmr;
    logic          unlocked, near_r;

    assign lock_dev = adiff(meas[act_r], zero_delay_setting ? meas[3] : meas[4]);

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            unlocked <= 1'b1;
            near_r   <= 1'b0;
            lol_tmr  <= '0;
        end
        else
        begin
            // Clear delay first, so a set later in the same cycle wins
            if (!near_r)
                lol_tmr <= '0;
            else if (lol_tmr >= lol_tmr_r[CW-1:0])
                unlocked <= 1'b0;
            else
                lol_tmr <= lol_tmr + 1'b1;
            if (holdover || switch_start)
            begin
                unlocked <= 1'b1;
                near_r   <= 1'b0;
            end
            else if (gate_end && meas_ok)
            begin
                if (lock_dev > lol_thr_r[CW-1:0])
                begin
                    unlocked <= 1'b1;
                    near_r   <= 1'b0;
                end
                else if (lock_dev <= lol_thr_r[16 +: CW])
                    near_r <= 1'b1;
            end
        end
    end

    assign unlocked_pin_n = !unlocked;

    // ==========================================================
    // Status assembly and sticky bits (set wins over clear)
    assign live = {19'h0, holdover, act_r, unlocked, xlos, freq_excursion_flag, signal_absent_flag};

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            sticky_r <= '0;
        else
            sticky_r <= (sticky_r & ~((ph_wr && ph_addr == isf_pkg::OFS_STICKY) ?
                         hwdata[STICKY_BITS_W-1:0] : '0)) |
                        live[STICKY_BITS_W-1:0];
    end

    // ==========================================================
    // AHB-Lite slave, zero wait states
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ph_act  <= 1'b0;
            ph_wr   <= 1'b0;
            ph_addr <= 8'h00;
        end
        else if (hready)
        begin
            ph_act  <= hsel && htrans[1];
            ph_wr   <= hsel && htrans[1] && hwrite;
            ph_addr <= (haddr[31:8] == 24'h0) ? haddr[7:0] : 8'hFF;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            hrdata <= 32'h0000_0000;
        else if (hready && hsel && htrans[1] && !hwrite)
        begin
            unique case ((haddr[31:8] == 24'h0) ? haddr[7:0] : 8'hFF)
                isf_pkg::OFS_CTRL:      hrdata <= ctrl_r;
                isf_pkg::OFS_PRIO:      hrdata <= prio_r;
                isf_pkg::OFS_LOS_LIM:   hrdata <= los_lim_r;
                isf_pkg::OFS_OOF_WIN:   hrdata <= oof_win_r;
                isf_pkg::OFS_OOF_EXP:   hrdata <= oof_exp_r;
                isf_pkg::OFS_LOL_THR:   hrdata <= lol_thr_r;
                isf_pkg::OFS_LOL_TIMER: hrdata <= lol_tmr_r;
                isf_pkg::OFS_LIVE:      hrdata <= live;
                isf_pkg::OFS_STICKY:    hrdata <= {22'h0, sticky_r};
                default:                hrdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_r    <= isf_pkg::CTRL_RST;
            prio_r    <= isf_pkg::PRIO_RST;
            los_lim_r <= isf_pkg::LOS_LIM_RST;
            oof_win_r <= isf_pkg::OOF_WIN_RST;
            oof_exp_r <= isf_pkg::OOF_EXP_RST;
            lol_thr_r <= isf_pkg::LOL_THR_RST;
            lol_tmr_r <= isf_pkg::LOL_TIMER_RST;
        end
        else if (ph_wr)
        begin
            case (ph_addr)
                isf_pkg::OFS_CTRL:      ctrl_r    <= hwdata;
                isf_pkg::OFS_PRIO:      prio_r    <= hwdata;
                isf_pkg::OFS_LOS_LIM:   los_lim_r <= hwdata;
                isf_pkg::OFS_OOF_WIN:   oof_win_r <= hwdata;
                isf_pkg::OFS_OOF_EXP:   oof_exp_r <= hwdata;
                isf_pkg::OFS_LOL_THR:   lol_thr_r <= hwdata;
                isf_pkg::OFS_LOL_TIMER: lol_tmr_r <= hwdata;
                default:                ;
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> tb/isf_ref_model.sv
// Reference clock sources, crystal and loop feedback model
`timescale 1ns/1ps
`default_nettype none
module isf_ref_model (
    input  wire logic [4:0] run,
    input  wire logic [1:0] active_input,
    input  wire logic       ext_feedback_en,
    output logic            ref_clock_a,
    output logic            ref_clock_b,
    output logic            ref_clock_c,
    output logic            ref_clock_d_or_feedback,
    output logic            loop_fb_clk,
    output logic            crystal_reference
);
    wire logic [4:0] ck;
    // ==========
    // Sources stop low when not running
    for (genvar i = 0; i < 5; i++)
    begin : g_src
        logic c = 1'b0;
        always #(30 + 5 * i) c = run[i] & ~c;
        assign ck[i] = c;
    end
    assign ref_clock_a = ck[0];
    assign ref_clock_b = ck[1];
    assign ref_clock_c = ck[2];
    assign crystal_reference = ck[4];
    assign loop_fb_clk = ck[active_input];
    assign ref_clock_d_or_feedback = ext_feedback_en ? loop_fb_clk : ck[3];
endmodule
`default_nettype wire

// >>> tb/isf_top_props.sv
// Assertions on the ports of the input select and fault monitor
`timescale 1ns/1ps
`default_nettype none
module isf_top_props (
    input wire logic        sys_clk,
    input wire logic        rst_b,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        unlocked_pin_n,
    input wire logic [1:0]  active_input,
    input wire logic        holdover,
    input wire logic        switch_start,
    input wire logic        hitless_en,
    input wire logic        ramp_en,
    input wire logic        fastlock_en,
    input wire logic        ext_feedback_en
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    // ==========
    // Control write and its data phase
    sequence ctrl_wr;
        hsel && hready && htrans[1] && hwrite && haddr == 32'h0000_0000 ##1 1'b1;
    endsequence
    a_hitless_copy: assert property (ctrl_wr |=> hitless_en == $past(hwdata[5]))
        else $error("hitless enable differs from written bit");
    a_ramp_copy: assert property (ctrl_wr |=> ramp_en == $past(hwdata[6]))
        else $error("ramp enable differs from written bit");
    a_fastlock_copy: assert property (ctrl_wr |=> fastlock_en == $past(hwdata[7]))
        else $error("fast lock enable differs from written bit");
    a_zero_delay_copy: assert property (ctrl_wr |=> ext_feedback_en == $past(hwdata[8]))
        else $error("zero delay enable differs from written bit");
    sequence zd_settled;
        ext_feedback_en && $past(ext_feedback_en, 4);
    endsequence
    a_zero_delay_excl: assert property (zd_settled |-> holdover || active_input != 2'h3)
        else $error("fourth input selected in zero delay");
    a_switch_unlock: assert property (switch_start |-> ##[0:2] !unlocked_pin_n)
        else $error("unlocked not shown after a switch");
    a_switch_pulse: assert property (switch_start && $past(switch_start) |-> $changed(active_input))
        else $error("switch start held without a new selection");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus slave stalled or answered with an error");
endmodule
bind isf_top isf_top_props u_props (
    .sys_clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp,
    .unlocked_pin_n, .active_input, .holdover, .switch_start, .hitless_en, .ramp_en,
    .fastlock_en, .ext_feedback_en
);
`default_nettype wire

// >>> tb/test_input_select_fault_monitor.sv
// Self-checking bench for the input select and fault monitor
`timescale 1ns/1ps
`default_nettype none
module test_input_select_fault_monitor;
    logic        sys_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [1:0]  in_sel_pins = 2'h0;
    logic [4:0]  run = 5'h1f;
    logic        hready, hreadyout, hresp, unlocked_pin_n, holdover, switch_start, outputs_enable;
    logic        hitless_en, ramp_en, fastlock_en, ext_feedback_en, loop_fb_clk, crystal_reference;
    logic        ref_clock_a, ref_clock_b, ref_clock_c, ref_clock_d_or_feedback, zd, rv;
    logic [1:0]  active_input;
    logic [31:0] hrdata, rd, seed = 32'h32ae_6aed;
    logic [11:0] pr;
    logic [3:0]  le, mk, ab, v;
    logic [2:0]  ex;
    int          miscompares = 0, check_count = 0, cyc = 0;
    logic [7:0]  rofs [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h24};
    logic [31:0] rval [8] = '{isf_pkg::CTRL_RST, isf_pkg::PRIO_RST, isf_pkg::LOS_LIM_RST,
        isf_pkg::OOF_WIN_RST, isf_pkg::OOF_EXP_RST, isf_pkg::LOL_THR_RST, isf_pkg::LOL_TIMER_RST,
        32'h0000_0000};
    assign hready = hreadyout;
    isf_top #(.GATE(64)) uut (
        .sys_clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
        .hreadyout, .hresp, .hrdata, .ref_clock_a, .ref_clock_b, .ref_clock_c,
        .ref_clock_d_or_feedback, .loop_fb_clk, .crystal_reference, .in_sel_pins,
        .unlocked_pin_n, .active_input, .holdover, .switch_start, .hitless_en, .ramp_en,
        .fastlock_en, .ext_feedback_en, .outputs_enable
    );
    isf_ref_model model (
        .run, .active_input, .ext_feedback_en, .ref_clock_a, .ref_clock_b, .ref_clock_c,
        .ref_clock_d_or_feedback, .loop_fb_clk, .crystal_reference
    );
    // ==========
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    // Highest priority valid input, lowest index on ties; bit 2 set when one exists
    function automatic logic [2:0] best(input logic [3:0] vl, input logic [11:0] p);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 3; i >= 0; i--)
            if (vl[i] && (!r[2] || p[3 * i +: 3] <= p[3 * r[1:0] +: 3]))
                r = {1'b1, 2'(i)};
        return r;
    endfunction
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        @(posedge sys_clk);
        while (hready !== 1'b1) @(posedge sys_clk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge sys_clk);
        while (hready !== 1'b1) @(posedge sys_clk);
        rd = hrdata;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic actl(input logic [3:0] l, input logic z, input logic r);
        bus(1'b1, isf_pkg::OFS_CTRL, {12'h000, 1'b1, 2'h0, l, 4'h0, z, seed[24:22], r, 4'h8});
    endtask
    task automatic sel_chk(input logic [2:0] e, input logic [3:0] a);
        chk("holdover", 32'(holdover), 32'(!e[2]));
        if (e[2])
            chk("active", 32'(active_input), 32'(e[1:0]));
        bus(1'b0, isf_pkg::OFS_LIVE, 32'h0000_0000);
        chk("live", 32'({rd[12], rd[2:0]}), 32'({!e[2], a[2:0]}));
    endtask
    task automatic final_report();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ==========
    // Clock and hang limit
    initial
    begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            miscompares++;
            final_report();
        end
    end
    // ==========
    // Main sequence
    initial
    begin
        wt(10);
        rst_b <= 1'b1;
        wt(3);
        for (int i = 0; i < 8; i++)
        begin
            bus(1'b0, rofs[i], 32'h0000_0000);
            chk("reset_value", rd, rval[i]);
        end
        bus(1'b1, isf_pkg::OFS_LOL_TIMER, 32'h0000_0010);
        for (int m = 0; m < 8; m++)
        begin
            in_sel_pins <= m[2] ? ~m[1:0] : m[1:0];
            bus(1'b1, isf_pkg::OFS_CTRL, {28'h0009_E00, 1'b0, m[2] ? m[1:0] : ~m[1:0], m[2]});
            wt(20);
            sel_chk({1'b1, m[1:0]}, 4'h0);
        end
        wt(400);
        chk("unlocked_pin", 32'(unlocked_pin_n), 32'h0000_0001);
        run[4] <= 1'b0;
        wt(150);
        chk("out_en_off", 32'(outputs_enable), 32'h0000_0000);
        bus(1'b1, isf_pkg::OFS_CTRL, 32'h0009_E200);
        wt(4);
        chk("out_en_keep", 32'(outputs_enable), 32'h0000_0001);
        run[4] <= 1'b1;
        for (int k = 0; k < 12; k++)
        begin
            seed = xs(seed);
            pr = seed[11:0] & 12'h6db;
            bus(1'b1, isf_pkg::OFS_PRIO, {20'h0_0000, pr});
            run <= 5'h1f;
            actl(4'hf, 1'b0, 1'b1);
            wt(400);
            ex = best(4'hf, pr);
            sel_chk(ex, 4'h0);
            chk("unlocked_pin", 32'(unlocked_pin_n), 32'h0000_0001);
            le = (k == 0) ? 4'hf : seed[17:14];
            zd = seed[12];
            rv = seed[13];
            mk = (k == 0) ? 4'h0 : seed[21:18];
            actl(le, zd, rv);
            run <= {1'b1, mk};
            wt(300);
            ab = ~mk & le;
            v = ~ab & ~{zd, 3'h0};
            if (zd && ex[1:0] == 2'h3)
                ex = best(4'h7, pr);
            if (rv || !v[ex[1:0]])
                ex = best(v, pr);
            sel_chk(ex, ab);
            bus(1'b1, isf_pkg::OFS_STICKY, 32'h0000_03ff);
            bus(1'b0, isf_pkg::OFS_STICKY, 32'h0000_0000);
            chk("sticky_absent", 32'(rd[2:0]), 32'(ab[2:0]));
        end
        // Excursion against input a, window 2, no hysteresis: b, c, d run 3 or more counts slower
        run <= 5'h1f;
        bus(1'b1, isf_pkg::OFS_OOF_WIN, 32'h0000_0002);
        bus(1'b1, isf_pkg::OFS_CTRL, 32'h000B_E418);
        wt(300);
        chk("active_excursion", 32'(active_input), 32'h0000_0000);
        bus(1'b0, isf_pkg::OFS_LIVE, 32'h0000_0000);
        chk("live_excursion", 32'(rd[7:4]), 32'h0000_000e);
        final_report();
    end
endmodule
`default_nettype wire
